// File: logic/ldrac_map.svh
// Register map, field positions, reset values and sizes for ldrac.
// Assumes an 8-bit register port with a 3-bit word address.
// What this block does
// - RAM reads and writes happen only while mixed mode is set.
// - In mixed mode the own subaddress is fixed at zero.
// - Three access modes, character, half-graphic, full-graphic, set by field.
// - The access mode sets the order of visited locations, reads and writes.
// - Each further byte goes to the next location with no new address.
// - Past the end of a device region the subaddress counts up, but holds at the last device.
// - Last device fifteen makes the subaddress wrap to zero.
// - Rows of RAM are shifted out to the columns continuously.
// - Rows per frame follow the two-bit multiplex field.
// - Display status gives blank, normal, all on or inverse.
// - Start bank picks the RAM bank at the top of the display.
// - Access code 00 char, 01 half, 10 full; 11 is illegal.
// - Column pointer is six bits, columns 0 to 39.
// - Row pointer is two bits, rows 0 to 3.
// - Start bank codes 00 to 11 select banks 0 to 3.
`ifndef LDRAC_MAP_SVH
`define LDRAC_MAP_SVH

`define LDRAC_A_MODE 3'h0
`define LDRAC_A_BANK 3'h1
`define LDRAC_A_SUB 3'h2
`define LDRAC_A_XADR 3'h3
`define LDRAC_A_ACC 3'h4
`define LDRAC_A_DATA 3'h5
`define LDRAC_A_STAT 3'h6
`define LDRAC_A_LAST 3'h7

`define LDRAC_MODE_MIX_BIT 4
`define LDRAC_MODE_RST 5'h00
`define LDRAC_LAST_RST 4'hF
`define LDRAC_OWN_SUB 4'h0
`define LDRAC_SUB_TOP 4'hF
`define LDRAC_COLS 40
`define LDRAC_LAST_COL 6'h27
`define LDRAC_LAST_ROW 2'h3
`define LDRAC_RAM_WORDS 160
`define LDRAC_FIFO_W 8
`define LDRAC_FIFO_D 16

`endif

// File: logic/ldrac_pkg.sv
// Types shared by the ldrac display RAM access and scan logic.
// Assumes nothing beyond a SystemVerilog-2012 compiler.
`default_nettype none

package ldrac_pkg;

    typedef enum logic [1:0] {
        LDRAC_G_CHAR = 2'b00,
        LDRAC_G_HALF = 2'b01,
        LDRAC_G_FULL = 2'b10,
        LDRAC_G_BAD = 2'b11
    } ldrac_access_e;

    typedef enum logic [1:0] {
        LDRAC_E_BLANK = 2'b00,
        LDRAC_E_NORMAL = 2'b01,
        LDRAC_E_ALLON = 2'b10,
        LDRAC_E_INVERSE = 2'b11
    } ldrac_status_e;

    typedef enum logic [1:0] {
        LDRAC_M_32 = 2'b00,
        LDRAC_M_8 = 2'b01,
        LDRAC_M_16 = 2'b10,
        LDRAC_M_24 = 2'b11
    } ldrac_mux_e;

    typedef struct packed {
        logic mixed;
        ldrac_status_e status;
        ldrac_mux_e mux;
    } ldrac_cfg_s;

    typedef struct packed {
        logic [3:0] sub;
        logic [5:0] x;
        logic [1:0] y;
        ldrac_access_e mode;
    } ldrac_ptr_s;

endpackage

`default_nettype wire

// File: logic/ldrac_top.sv
// Display RAM access control and row scan, with its write data FIFO.
// Assumes a same-clock register master and a display clock from a pin.
//
// Chosen here: the placing of the registers and the strobed register port.
`include "ldrac_map.svh"
`default_nettype none

module ldrac_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_ff [D];
    logic [AW-1:0] wptr_ff;
    logic [AW-1:0] rptr_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    assign o_in_ready = (cnt_ff != (AW+1)'(D));
    assign o_out_valid = (cnt_ff != '0);
    assign o_out_data = mem_ff[rptr_ff];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem_ff[wptr_ff] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff <= '0;
        end else if (i_ce) begin
            if (push) begin
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (pop) begin
                rptr_ff <= rptr_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule

module ldrac_top (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_data_ready,
    input wire logic i_disp_clk,
    output logic [`LDRAC_COLS-1:0] o_col,
    output logic [4:0] o_row,
    output logic o_frame_sync,
    output logic [3:0] o_sub
);
    ldrac_pkg::ldrac_cfg_s cfg_ff;
    ldrac_pkg::ldrac_ptr_s ptr_ff;
    ldrac_pkg::ldrac_ptr_s nxt_ptr;
    logic [1:0] bank_ff;
    logic [3:0] last_ff;
    logic [7:0] ram_ff [`LDRAC_RAM_WORDS];
    logic [7:0] rdata_ff;
    logic ready_ff;
    logic [`LDRAC_COLS-1:0] col_ff;
    logic [4:0] row_ff;
    logic [4:0] scan_row_ff;
    logic sync_ff;
    logic dclk_s1_ff;
    logic dclk_s2_ff;
    logic dclk_s3_ff;
    logic scan_edge;
    logic [4:0] row_last;
    logic [1:0] scan_bank;
    logic [`LDRAC_COLS-1:0] col_raw;
    logic [7:0] ptr_idx;
    logic own_sel;
    logic wr_data;
    logic rd_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic drain;
    logic [7:0] fifo_out_data;
    logic [7:0] rd_value;

    assign o_rdata = rdata_ff;
    assign o_data_ready = ready_ff;
    assign o_col = col_ff;
    assign o_row = row_ff;
    assign o_frame_sync = sync_ff;
    assign o_sub = ptr_ff.sub;

    // Next location for the current access mode
    function automatic ldrac_pkg::ldrac_ptr_s step_ptr(
        input ldrac_pkg::ldrac_ptr_s p,
        input logic [3:0] last
    );
        ldrac_pkg::ldrac_ptr_s n;
        logic wrap;
        n = p;
        wrap = 1'b0;
        unique case (p.mode)
            ldrac_pkg::LDRAC_G_CHAR: begin
                // Along a row, then down one row
                if (p.x == `LDRAC_LAST_COL) begin
                    n.x = '0;
                    if (p.y == `LDRAC_LAST_ROW) begin
                        wrap = 1'b1;
                    end else begin
                        n.y = p.y + 1'b1;
                    end
                end else begin
                    n.x = p.x + 1'b1;
                end
            end
            ldrac_pkg::LDRAC_G_HALF: begin
                // Two rows per column, then the next pair
                if (!p.y[0]) begin
                    n.y[0] = 1'b1;
                end else begin
                    n.y[0] = 1'b0;
                    if (p.x == `LDRAC_LAST_COL) begin
                        n.x = '0;
                        if (p.y[1]) begin
                            wrap = 1'b1;
                        end else begin
                            n.y[1] = 1'b1;
                        end
                    end else begin
                        n.x = p.x + 1'b1;
                    end
                end
            end
            ldrac_pkg::LDRAC_G_FULL: begin
                // All four rows per column
                if (p.y != `LDRAC_LAST_ROW) begin
                    n.y = p.y + 1'b1;
                end else begin
                    n.y = '0;
                    if (p.x == `LDRAC_LAST_COL) begin
                        wrap = 1'b1;
                    end else begin
                        n.x = p.x + 1'b1;
                    end
                end
            end
            default: begin
                n = p;
            end
        endcase
        if (wrap) begin
            // Region ended: move on to the next device, or hold at the last one
            n.x = '0;
            n.y = '0;
            if (p.sub == last && last != `LDRAC_SUB_TOP) begin
                n.sub = p.sub;
            end else begin
                // Four-bit roll-over gives fifteen to zero
                n.sub = p.sub + 1'b1;
            end
        end
        return n;
    endfunction

    // Own RAM answers only subaddress zero
    assign own_sel = (ptr_ff.sub == `LDRAC_OWN_SUB);
    assign ptr_idx = 8'(ptr_ff.y) * 8'h28 + 8'(ptr_ff.x);
    assign wr_data = i_wr && (i_addr == `LDRAC_A_DATA) && cfg_ff.mixed;
    assign rd_data = i_rd && (i_addr == `LDRAC_A_DATA) && cfg_ff.mixed;
    // Drain yields to bus traffic and to the row latch so pointers
    // and the latched row never see a half-applied byte.
    assign drain = fifo_out_valid && cfg_ff.mixed && !i_wr && !i_rd
        && !scan_edge;
    assign nxt_ptr = step_ptr(ptr_ff, last_ff);

    ldrac_fifo #(
        .W(`LDRAC_FIFO_W),
        .D(`LDRAC_FIFO_D)
    ) u_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_in_valid(wr_data),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_wdata),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(drain),
        .o_out_data(fifo_out_data)
    );

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            // Power-up blanks the display
            cfg_ff <= ldrac_pkg::ldrac_cfg_s'(`LDRAC_MODE_RST);
            bank_ff <= '0;
            last_ff <= `LDRAC_LAST_RST;
        end else if (i_ce && i_wr) begin
            if (i_addr == `LDRAC_A_MODE) begin
                cfg_ff <= ldrac_pkg::ldrac_cfg_s'(i_wdata[4:0]);
            end
            if (i_addr == `LDRAC_A_BANK) begin
                bank_ff <= i_wdata[1:0];
            end
            if (i_addr == `LDRAC_A_LAST) begin
                last_ff <= i_wdata[3:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ptr_ff <= '0;
        end else if (i_ce) begin
            if (i_wr && i_addr == `LDRAC_A_SUB) begin
                ptr_ff.sub <= i_wdata[3:0];
            end else if (i_wr && i_addr == `LDRAC_A_XADR) begin
                ptr_ff.x <= i_wdata[5:0];
            end else if (i_wr && i_addr == `LDRAC_A_ACC) begin
                ptr_ff.y <= i_wdata[1:0];
                // Code 11 is refused and the old mode kept
                if (i_wdata[3:2] != 2'b11) begin
                    ptr_ff.mode <= ldrac_pkg::ldrac_access_e'(i_wdata[3:2]);
                end
            end else if (drain || rd_data) begin
                ptr_ff <= nxt_ptr;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_ce && drain && own_sel) begin
            ram_ff[ptr_idx] <= fifo_out_data;
        end
    end

    always_comb begin
        rd_value = 8'h00;
        unique case (i_addr)
            `LDRAC_A_MODE: rd_value = {3'h0, cfg_ff};
            `LDRAC_A_BANK: rd_value = {6'h00, bank_ff};
            `LDRAC_A_SUB: rd_value = {4'h0, ptr_ff.sub};
            `LDRAC_A_XADR: rd_value = {2'h0, ptr_ff.x};
            `LDRAC_A_ACC: rd_value = {4'h0, ptr_ff.mode, ptr_ff.y};
            `LDRAC_A_DATA: begin
                if (rd_data && own_sel) begin
                    rd_value = ram_ff[ptr_idx];
                end
            end
            `LDRAC_A_STAT: begin
                rd_value = {scan_row_ff, cfg_ff.mixed, !fifo_in_ready,
                    !fifo_out_valid};
            end
            `LDRAC_A_LAST: rd_value = {4'h0, last_ff};
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_ff <= 8'h00;
            ready_ff <= 1'b0;
        end else if (i_ce) begin
            rdata_ff <= i_rd ? rd_value : 8'h00;
            ready_ff <= fifo_in_ready && cfg_ff.mixed;
        end
    end

    // Display clock comes from a pin; two stages before use
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            dclk_s1_ff <= 1'b0;
            dclk_s2_ff <= 1'b0;
            dclk_s3_ff <= 1'b0;
        end else if (i_ce) begin
            dclk_s1_ff <= i_disp_clk;
            dclk_s2_ff <= dclk_s1_ff;
            dclk_s3_ff <= dclk_s2_ff;
        end
    end

    assign scan_edge = dclk_s2_ff && !dclk_s3_ff;

    always_comb begin
        row_last = 5'h1F;
        unique case (cfg_ff.mux)
            ldrac_pkg::LDRAC_M_8: row_last = 5'h07;
            ldrac_pkg::LDRAC_M_16: row_last = 5'h0F;
            ldrac_pkg::LDRAC_M_24: row_last = 5'h17;
            ldrac_pkg::LDRAC_M_32: row_last = 5'h1F;
        endcase
    end

    // Each bank holds eight display rows
    assign scan_bank = bank_ff + scan_row_ff[4:3];

    genvar c;
    generate
        for (c = 0; c < `LDRAC_COLS; c++) begin : g_col
            assign col_raw[c] =
                ram_ff[8'(scan_bank) * 8'h28 + 8'(c)][scan_row_ff[2:0]];
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            scan_row_ff <= '0;
            row_ff <= '0;
            col_ff <= '0;
            sync_ff <= 1'b0;
        end else if (i_ce) begin
            sync_ff <= scan_edge && (scan_row_ff == 5'h00);
            if (scan_edge) begin
                row_ff <= scan_row_ff;
                unique case (cfg_ff.status)
                    ldrac_pkg::LDRAC_E_BLANK: begin
                        col_ff <= '0;
                    end
                    ldrac_pkg::LDRAC_E_NORMAL: begin
                        col_ff <= col_raw;
                    end
                    ldrac_pkg::LDRAC_E_ALLON: begin
                        col_ff <= '1;
                    end
                    ldrac_pkg::LDRAC_E_INVERSE: begin
                        col_ff <= ~col_raw;
                    end
                endcase
                // A shortened mux rate may leave the row past its end
                if (scan_row_ff >= row_last) begin
                    scan_row_ff <= '0;
                end else begin
                    scan_row_ff <= scan_row_ff + 1'b1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// File: tb/ldrac_disp_src.sv
// Free-running row clock source for the scan input of ldrac_top.
// Assumes the scan clock never stops, as a display needs it to.
`default_nettype none
module ldrac_disp_src #(
    parameter int HALF_NS = 200
) (
    output logic o_disp_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    // Odd start offset keeps it out of phase with the system clock
    initial begin
        o_disp_clk = 1'b0;
        #7;
        forever #(HALF_NS) o_disp_clk = ~o_disp_clk;
    end
endmodule
`default_nettype wire

// File: tb/ldrac_top_asserts.sv
// Port timing checker for ldrac_top, bound to every instance.
// Assumes i_ce never drops for more than two cycles at a time.
`include "ldrac_map.svh"
`default_nettype none
module ldrac_top_chk (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_data_ready,
    input wire logic i_disp_clk,
    input wire logic [4:0] o_row,
    input wire logic o_frame_sync,
    input wire logic [3:0] o_sub
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_disp_rise;
        !i_disp_clk ##1 i_disp_clk;
    endsequence
    // First latch after reset repeats row zero; the sync pulse marks it
    sequence s_row_move;
        ##[1:6] ($changed(o_row) || o_frame_sync);
    endsequence
    chk_scan_runs: assert property (s_disp_rise |-> s_row_move)
        else $error("row did not advance on display clock");
    chk_row_hold: assert property ($changed(o_row)
        |-> $past(i_disp_clk, 2))
        else $error("row moved without display clock");
    chk_row_step: assert property ($changed(o_row) |->
        (o_row == 5'($past(o_row) + 5'h01)) || (o_row == 5'h00))
        else $error("row index skipped");
    chk_sync_row0: assert property (o_frame_sync |->
        o_row == 5'h00)
        else $error("frame sync away from row zero");
    chk_sync_pulse: assert property (o_frame_sync |=>
        !o_frame_sync)
        else $error("frame sync longer than one cycle");
    chk_ready_off: assert property ((i_wr
        && i_addr == `LDRAC_A_MODE
        && !i_wdata[`LDRAC_MODE_MIX_BIT]) |-> ##2 !o_data_ready)
        else $error("data ready while not mixed");
    chk_sub_step: assert property (($changed(o_sub)
        && !$past(i_wr && i_addr == `LDRAC_A_SUB))
        |-> o_sub == 4'($past(o_sub) + 4'h1))
        else $error("subaddress moved by other than one");
    chk_col_range: assert property ($past(i_rd
        && i_addr == `LDRAC_A_XADR) |-> o_rdata < 8'h28)
        else $error("column pointer beyond last column");
    chk_acc_legal: assert property ($past(i_rd
        && i_addr == `LDRAC_A_ACC)
        |-> o_rdata[7:4] == 4'h0 && o_rdata[3:2] != 2'b11)
        else $error("illegal access mode held");
endmodule
bind ldrac_top ldrac_top_chk i_chk (.i_clk(i_clk), .i_srst(i_srst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_data_ready(o_data_ready),
    .i_disp_clk(i_disp_clk), .o_row(o_row),
    .o_frame_sync(o_frame_sync), .o_sub(o_sub));
`default_nettype wire

// File: tb/lcd_display_ram_access_control_tb_top.sv
// Self-checking bench for ldrac_top: registers, walks, FIFO and scan.
// Assumes ldrac_disp_src drives the row clock; i_ce drops only briefly.
`include "ldrac_map.svh"
`default_nettype none
module lcd_display_ram_access_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_ce = 1'b1;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata, b, q [4];
    logic o_data_ready, o_frame_sync, disp;
    logic [`LDRAC_COLS-1:0] o_col;
    logic [4:0] o_row;
    logic [3:0] o_sub;
    logic [5:0] x, ex;
    logic [1:0] y, ey, g;
    logic [3:0] ts [3] = '{4'hF, 4'h1, 4'h2}, tl [3] = '{4'hF, 4'h2, 4'h2};
    logic [3:0] te [3] = '{4'h0, 4'h2, 4'h2};
    logic [7:0] tm [8] = '{8'h15, 8'h15, 8'h1D, 8'h19, 8'h11, 8'h16, 8'h17,
        8'h14};
    logic [1:0] tk [8] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
    logic [7:0] tv [8] = '{8'h0, 8'h1, 8'h1, 8'h1, 8'h0, 8'h0, 8'h0, 8'h0};
    logic [7:0] tr [8] = '{8'd8, 8'd8, 8'd8, 8'd8, 8'd8, 8'd16, 8'd24, 8'd32};
    int n_errors = 0, total_checks = 0, cyc = 0, n;

    ldrac_top i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_data_ready(o_data_ready), .i_disp_clk(disp),
        .o_col(o_col), .o_row(o_row), .o_frame_sync(o_frame_sync),
        .o_sub(o_sub));
    ldrac_disp_src i_src (.o_disp_clk(disp));

    always #25 i_clk = ~i_clk;
    // Run needs about 2000 cycles; the ceiling leaves ample margin
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Write strobe stays up so that writes follow with no gap
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b0;
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic drain();
        for (int i = 0; i < 40; i++) begin
            rd(`LDRAC_A_STAT, b);
            if (b[0] === 1'b1) break;
        end
    endtask
    task automatic sync_wait(inout int cnt);
        for (int i = 0; i < 400; i++) begin
            @(posedge i_clk);
            i_wr <= 1'b0;
            #1 cnt++;
            if (o_frame_sync === 1'b1) break;
        end
    endtask
    task automatic step(inout logic [5:0] px, inout logic [1:0] py);
        if (g == 2'b00) px++;
        else if (g == 2'b01) begin
            if (!py[0]) py[0] = 1'b1;
            else begin
                py[0] = 1'b0;
                px++;
            end
        end else begin
            py++;
            if (py == 2'h0) px++;
        end
    endtask

    initial begin
        void'($urandom(16));
        repeat (20) @(posedge i_clk);
        i_srst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            if (a == 5 || a == 6) continue;
            rd(3'(a), b);
            check(b, a == 7 ? 8'h0F : 8'h00);
        end
        wr(`LDRAC_A_DATA, 8'hA5);
        rd(`LDRAC_A_STAT, b);
        check({5'h0, b[2:0]}, 8'h01);
        rd(`LDRAC_A_DATA, b);
        check(b, 8'h00);
        rd(`LDRAC_A_XADR, b);
        check(b, 8'h00);
        check({7'h0, o_data_ready}, 8'h00);
        $display("idle mode tests done");
        wr(`LDRAC_A_MODE, 8'h15);
        for (int m = 0; m < 3; m++) begin
            g = 2'(m);
            x = 6'($urandom_range(35));
            y = 2'($urandom);
            for (int k = 0; k < 2; k++) begin
                wr(`LDRAC_A_XADR, {2'h0, x});
                wr(`LDRAC_A_ACC, {4'h0, g, y});
                for (int j = 0; j < 4; j++) begin
                    if (k == 0) begin
                        q[j] = 8'($urandom);
                        wr(`LDRAC_A_DATA, q[j]);
                    end else begin
                        rd(`LDRAC_A_DATA, b);
                        check(b, q[j]);
                    end
                end
                drain();
                ex = x;
                ey = y;
                repeat (4) step(ex, ey);
                rd(`LDRAC_A_XADR, b);
                check(b, {2'h0, ex});
                rd(`LDRAC_A_ACC, b);
                check(b, {4'h0, g, ey});
            end
        end
        wr(`LDRAC_A_ACC, 8'h0E);
        rd(`LDRAC_A_ACC, b);
        check(b, 8'h0A);
        $display("walk tests done");
        // Known zero at own location 0 for the wrapped read-back below
        wr(`LDRAC_A_SUB, 8'h00);
        wr(`LDRAC_A_XADR, 8'h00);
        wr(`LDRAC_A_ACC, 8'h00);
        wr(`LDRAC_A_DATA, 8'h00);
        drain();
        for (int t = 0; t < 3; t++) begin
            wr(`LDRAC_A_LAST, {4'h0, tl[t]});
            wr(`LDRAC_A_SUB, {4'h0, ts[t]});
            wr(`LDRAC_A_XADR, 8'h27);
            wr(`LDRAC_A_ACC, 8'h03);
            wr(`LDRAC_A_DATA, 8'h5A);
            drain();
            check({4'h0, o_sub}, {4'h0, te[t]});
            rd(`LDRAC_A_DATA, b);
            check(b, 8'h00);
        end
        $display("cascade tests done");
        wr(`LDRAC_A_SUB, 8'h00);
        wr(`LDRAC_A_XADR, 8'h00);
        wr(`LDRAC_A_ACC, 8'h00);
        for (int j = 0; j < 17; j++) wr(`LDRAC_A_DATA, 8'(j));
        rd(`LDRAC_A_STAT, b);
        check({6'h0, b[1:0]}, 8'h02);
        check({7'h0, o_data_ready}, 8'h00);
        drain();
        rd(`LDRAC_A_XADR, b);
        check(b, 8'h10);
        check({7'h0, o_data_ready}, 8'h01);
        // Enable low: a write must be lost and the pointer frozen
        @(posedge i_clk);
        i_ce <= 1'b0;
        wr(`LDRAC_A_XADR, 8'h11);
        @(posedge i_clk);
        i_ce <= 1'b1;
        i_wr <= 1'b0;
        rd(`LDRAC_A_XADR, b);
        check(b, 8'h10);
        $display("fifo tests done");
        wr(`LDRAC_A_XADR, 8'h00);
        wr(`LDRAC_A_ACC, 8'h08);
        wr(`LDRAC_A_DATA, 8'h00);
        wr(`LDRAC_A_DATA, 8'hFF);
        wr(`LDRAC_A_DATA, 8'h00);
        wr(`LDRAC_A_DATA, 8'h00);
        drain();
        for (int t = 0; t < 8; t++) begin
            wr(`LDRAC_A_MODE, tm[t]);
            wr(`LDRAC_A_BANK, {6'h0, tk[t]});
            sync_wait(n);
            n = 0;
            sync_wait(n);
            check({7'h0, o_col[0]}, tv[t]);
            check(8'(n / 8), tr[t]);
        end
        $display("scan tests done");
        wr(`LDRAC_A_MODE, 8'h05);
        rd(`LDRAC_A_STAT, b);
        check({7'h0, b[2]}, 8'h00);
        check({7'h0, o_data_ready}, 8'h00);
        $display("mode off tests done");
        conclude();
    end
endmodule
`default_nettype wire
